// ==== logic/fbl_pkg.sv ====
package fbl_pkg;

   // Opcodes decoded by this block.
   localparam logic [7:0] OP_RD_LOCK_A     = 8'h3C;
   localparam logic [7:0] OP_RD_LOCK_B     = 8'h3D;
   localparam logic [7:0] OP_GLOBAL_LOCK   = 8'h7E;
   localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
   localparam logic [7:0] OP_OTP_PROG      = 8'h9B;

   // Serial framing: opcode bits, then opcode plus three address bytes.
   localparam logic [5:0] CMD_CNT = 6'h08;
   localparam logic [5:0] HDR_CNT = 6'h20;
   localparam logic [2:0] BIT_MSB = 3'h7;

   // Array geometry: each lock bit covers one 4KB region.
   localparam int BLOCK_SHIFT = 12;
   localparam int ADDR_W      = 24;

   // Security register map: bits 8:7 pick the register, 6:0 the byte.
   localparam int         OTP_REGS    = 4;
   localparam int         OTP_BYTES   = 128;
   localparam int         OTP_AW      = 9;
   localparam int         OTP_SEL_LSB = 7;
   localparam logic [6:0] OTP_MSB_OFS = 7'h7F;
   localparam logic [1:0] OTP_FACTORY = 2'h0;
   localparam logic [7:0] OTP_ERASED  = 8'hFF;

   // Value driven on the undefined upper bits of the lock status byte.
   localparam logic [6:0] LOCK_PAD = 7'h00;

   // Frame decoder states.
   typedef enum logic [2:0] {
      FBL_CMD,
      FBL_ADDR,
      FBL_TAIL,
      FBL_LOCK_RD,
      FBL_OTP_DATA
   } fbl_frame_t;

endpackage

// ==== logic/fbl_mem_if.sv ====
`timescale 1ns/10ps
// Write and read port of the security register store.
interface fbl_mem_if #(
   parameter int AW = 9,
   parameter int DW = 8
);
   logic          wr_en;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;
   logic [AW-1:0] rd_addr;
   logic [DW-1:0] rd_data;

   modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ==== logic/fbl_otp_mem.sv ====
`timescale 1ns/10ps
// Security register store; every byte starts erased and reads out of a register.
module fbl_otp_mem
   import fbl_pkg::*;
#(
   parameter int DEPTH = OTP_REGS * OTP_BYTES,
   parameter int AW    = OTP_AW,
   parameter int DW    = 8
) (
   input wire logic clock,  // System clock.
   input wire logic resetn, // Asynchronous reset, active low.
   fbl_mem_if.mem   port    // Write and read port.
);

   logic [DW-1:0] mem_q [DEPTH];
   logic [DW-1:0] rd_q;

   // The depth must fit the address width.
   if (DEPTH > (1 << AW) || DW != 8) begin : g_chk
      $error("fbl_otp_mem: unsupported depth or width");
   end

   // Store the written byte and register the read byte.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= OTP_ERASED;
         end
         rd_q <= '0;
      end else begin
         if (port.wr_en) begin
            mem_q[port.wr_addr] <= port.wr_data;
         end
         rd_q <= mem_q[port.rd_addr];
      end
   end

   assign port.rd_data = rd_q;

endmodule

// ==== logic/fbl_top.sv ====
`timescale 1ns/10ps
// Summary of operation
// (R1) Opcodes 3Ch and 3Dh both run the same read-lock-status operation.
// (R2) All block lock bits are set to one after reset.
// (R3) Host issues read-lock-status only with per-block protection selected.
// (R4) Host must not judge region protection from the read-lock-status answer.
// (R5) Read-lock-status: opcode then 24 address bits MSB first, then data out.
// (R6) Status byte is eight clocks MSB first; bit 0 is the lock bit.
// (R7) With chip select held low the same status byte repeats.
// (R8) The lock bit reported is that of the 4KB region holding the address.
// (R9) Host sends full opcode and address before raising chip select.
// (R10) Global lock opcode alone sets every block lock bit.
// (R11) Global unlock opcode alone clears every block lock bit.
// (R12) Host sets the write latch before global lock or unlock.
// (R13) On chip select rise after a valid global command, act and clear latch.
// (R14) Chip select rising off a byte boundary aborts global commands.
// (R15) Four 128-byte security registers sit apart from the array.
// (R16) Security bytes 0-127 are factory, 128-511 form user registers 1 to 3.
// (R17) Host sets the write latch before the security program opcode.
// (R18) Security program opcode and address arrive on the serial input.
// (R19) Address bits 8:7 pick the register, 6:0 the byte; the rest ignored.
// (R20) Programming a user register's top byte locks it and sets its flag.
// (R21) Lock, unlock and security program are ignored with the latch clear.
module fbl_top
   import fbl_pkg::*;
#(
   parameter int NUM_BLOCKS = 128
) (
   input  wire logic                  clock,            // System clock, 10 MHz.
   input  wire logic                  resetn,           // Asynchronous reset, active low.
   input  wire logic                  cs_n,             // Serial chip select, active low.
   input  wire logic                  sclk,             // Serial clock from the host.
   input  wire logic                  si,               // Serial data in.
   output logic                       so,               // Serial data out.
   output logic                       so_oe,            // Serial out drive enable.
   input  wire logic                  write_latch_flag, // Write enable latch state.
   output logic                       wel_clear,        // Pulse that clears the latch.
   output logic [NUM_BLOCKS-1:0]      block_lock,       // Per-block lock bits.
   output logic [OTP_REGS-2:0]        otp_lock_flags    // User security register locks.
);

   localparam int BLK_W = $clog2(NUM_BLOCKS);

   // The block index must fit inside the address field.
   if (NUM_BLOCKS < 2 || BLOCK_SHIFT + BLK_W > ADDR_W) begin : g_chk
      $error("fbl_top: unsupported block count");
   end

   fbl_mem_if #(.AW(OTP_AW), .DW(8)) mem_bus ();

   fbl_otp_mem #(.DEPTH(OTP_REGS * OTP_BYTES), .AW(OTP_AW), .DW(8)) u_mem ( // [R15]
      .clock  (clock),
      .resetn (resetn),
      .port   (mem_bus.mem)
   );

   // Pin synchronisers and their filtered levels.
   logic [2:0] cs_s_q, sclk_s_q, si_s_q;
   logic       cs_st_q, sclk_st_q, si_st_q;
   logic       cs_st_d, sclk_st_d, si_st_d;
   logic       sclk_rise, sclk_fall, cs_rise;

   // Frame decoder state.
   fbl_frame_t              state_q, state_d;
   logic [5:0]              cnt_q, cnt_d;
   logic [2:0]              bit_q, bit_d;
   logic [31:0]             shift_q, shift_d;
   logic [7:0]              opcode_q, opcode_d;
   logic [7:0]              out_q, out_d;
   logic [2:0]              oidx_q, oidx_d;
   logic                    so_q, so_d;
   logic                    so_oe_q, so_oe_d;
   logic [NUM_BLOCKS-1:0]   lock_q, lock_d;
   logic                    wel_clr_q, wel_clr_d;
   logic [OTP_REGS-2:0]     flags_q, flags_d;
   logic                    otp_ok_q, otp_ok_d;
   logic [1:0]              chk_q, chk_d;
   logic [OTP_AW-1:0]       otp_addr_q, otp_addr_d;
   logic                    wr_q, wr_d;
   logic [OTP_AW-1:0]       wr_addr_q, wr_addr_d;
   logic [7:0]              wr_data_q, wr_data_d;
   logic [OTP_AW-1:0]       rd_addr_q, rd_addr_d;

   // True for either read-lock-status opcode.
   function automatic logic is_rd_lock(input logic [7:0] op);
      return (op == OP_RD_LOCK_A) || (op == OP_RD_LOCK_B); // [R1]
   endfunction

   // True for the two whole-array lock opcodes.
   function automatic logic is_global(input logic [7:0] op);
      return (op == OP_GLOBAL_LOCK) || (op == OP_GLOBAL_UNLOCK);
   endfunction

   // A level change counts once the second and third stages agree.
   always_comb begin
      cs_st_d   = (cs_s_q[1] == cs_s_q[2]) ? cs_s_q[2] : cs_st_q;
      sclk_st_d = (sclk_s_q[1] == sclk_s_q[2]) ? sclk_s_q[2] : sclk_st_q;
      si_st_d   = (si_s_q[1] == si_s_q[2]) ? si_s_q[2] : si_st_q;
      sclk_rise = sclk_st_d & ~sclk_st_q;
      sclk_fall = ~sclk_st_d & sclk_st_q;
      cs_rise   = cs_st_d & ~cs_st_q;
   end

   // Register the synchroniser stages and filtered levels.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cs_s_q    <= 3'h7;
         sclk_s_q  <= 3'h0;
         si_s_q    <= 3'h0;
         cs_st_q   <= 1'b1;
         sclk_st_q <= 1'b0;
         si_st_q   <= 1'b0;
      end else begin
         cs_s_q    <= {cs_s_q[1:0], cs_n};
         sclk_s_q  <= {sclk_s_q[1:0], sclk};
         si_s_q    <= {si_s_q[1:0], si};
         cs_st_q   <= cs_st_d;
         sclk_st_q <= sclk_st_d;
         si_st_q   <= si_st_d;
      end
   end

   // Decode the frame, act on chip select rising and drive the status byte.
   always_comb begin
      logic [31:0] word;
      logic [7:0]  data;
      logic [1:0]  sel;
      word       = {shift_q[30:0], si_st_q};
      data       = word[7:0];
      sel        = otp_addr_q[OTP_AW-1:OTP_SEL_LSB];
      state_d    = state_q;
      cnt_d      = cnt_q;
      bit_d      = bit_q;
      shift_d    = shift_q;
      opcode_d   = opcode_q;
      out_d      = out_q;
      oidx_d     = oidx_q;
      so_d       = so_q;
      so_oe_d    = so_oe_q;
      lock_d     = lock_q;
      wel_clr_d  = 1'b0;
      flags_d    = flags_q;
      otp_ok_d   = otp_ok_q;
      chk_d      = {chk_q[0], 1'b0};
      otp_addr_d = otp_addr_q;
      wr_d       = 1'b0;
      wr_addr_d  = wr_addr_q;
      wr_data_d  = wr_data_q;
      rd_addr_d  = rd_addr_q;
      if (cs_st_q) begin
         state_d  = FBL_CMD;
         cnt_d    = '0;
         bit_d    = '0;
         oidx_d   = BIT_MSB;
         so_oe_d  = 1'b0;
         otp_ok_d = 1'b0;
      end else if (cs_rise) begin
         so_oe_d = 1'b0;
         // Global commands act only on a byte boundary with the latch set.
         if (state_q == FBL_TAIL && bit_q == 3'h0 && is_global(opcode_q)
             && write_latch_flag) begin // [R14] [R21]
            lock_d    = (opcode_q == OP_GLOBAL_LOCK) ? '1 : '0; // [R10] [R11]
            wel_clr_d = 1'b1; // [R13]
         end
         if (state_q == FBL_OTP_DATA && otp_ok_q && bit_q == 3'h0) begin
            wel_clr_d = 1'b1;
         end
      end else begin
         // Security program admission once the top byte has been read back.
         if (chk_q[1]) begin
            otp_ok_d = write_latch_flag && sel != OTP_FACTORY // [R16] [R21]
                       && mem_bus.rd_data == OTP_ERASED
                       && !flags_q[2'(sel - 2'h1)]; // [R20]
         end
         if (sclk_rise) begin
            shift_d = word;
            bit_d   = 3'(bit_q + 3'h1);
            if (cnt_q != HDR_CNT) begin
               cnt_d = 6'(cnt_q + 6'h01);
            end
            unique case (state_q)
               FBL_CMD: begin
                  if (cnt_q == CMD_CNT - 6'h01) begin
                     opcode_d = data;
                     state_d  = (is_rd_lock(data) || data == OP_OTP_PROG) ?
                                FBL_ADDR : FBL_TAIL; // [R18]
                  end
               end
               FBL_ADDR: begin
                  if (cnt_q == HDR_CNT - 6'h01) begin // [R5]
                     if (is_rd_lock(opcode_q)) begin
                        out_d   = {LOCK_PAD, lock_q[word[BLOCK_SHIFT +: BLK_W]]}; // [R6] [R8]
                        state_d = FBL_LOCK_RD;
                     end else begin
                        otp_addr_d = word[OTP_AW-1:0]; // [R19]
                        rd_addr_d  = {word[OTP_AW-1:OTP_SEL_LSB], OTP_MSB_OFS};
                        chk_d      = 2'b01;
                        state_d    = FBL_OTP_DATA;
                     end
                  end
               end
               FBL_OTP_DATA: begin
                  if (bit_q == BIT_MSB && otp_ok_q) begin
                     wr_d       = 1'b1;
                     wr_addr_d  = otp_addr_q;
                     wr_data_d  = data;
                     otp_addr_d = {sel, 7'(otp_addr_q[OTP_SEL_LSB-1:0] + 7'h01)};
                     if (otp_addr_q[OTP_SEL_LSB-1:0] == OTP_MSB_OFS
                         && data != OTP_ERASED) begin
                        flags_d[2'(sel - 2'h1)] = 1'b1; // [R20]
                        otp_ok_d                = 1'b0;
                     end
                  end
               end
               FBL_TAIL, FBL_LOCK_RD: begin
               end
            endcase
         end
         // Status bits leave on the falling edge, wrapping to repeat the byte.
         if (sclk_fall && state_q == FBL_LOCK_RD) begin
            so_d    = out_q[oidx_q]; // [R6]
            oidx_d  = 3'(oidx_q - 3'h1); // [R7]
            so_oe_d = 1'b1;
         end
      end
   end

   // Register the frame decoder state.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_q    <= FBL_CMD;
         cnt_q      <= '0;
         bit_q      <= '0;
         shift_q    <= '0;
         opcode_q   <= '0;
         out_q      <= '0;
         oidx_q     <= BIT_MSB;
         so_q       <= 1'b0;
         so_oe_q    <= 1'b0;
         lock_q     <= '1; // [R2]
         wel_clr_q  <= 1'b0;
         flags_q    <= '0;
         otp_ok_q   <= 1'b0;
         chk_q      <= '0;
         otp_addr_q <= '0;
         wr_q       <= 1'b0;
         wr_addr_q  <= '0;
         wr_data_q  <= '0;
         rd_addr_q  <= '0;
      end else begin
         state_q    <= state_d;
         cnt_q      <= cnt_d;
         bit_q      <= bit_d;
         shift_q    <= shift_d;
         opcode_q   <= opcode_d;
         out_q      <= out_d;
         oidx_q     <= oidx_d;
         so_q       <= so_d;
         so_oe_q    <= so_oe_d;
         lock_q     <= lock_d;
         wel_clr_q  <= wel_clr_d;
         flags_q    <= flags_d;
         otp_ok_q   <= otp_ok_d;
         chk_q      <= chk_d;
         otp_addr_q <= otp_addr_d;
         wr_q       <= wr_d;
         wr_addr_q  <= wr_addr_d;
         wr_data_q  <= wr_data_d;
         rd_addr_q  <= rd_addr_d;
      end
   end

   // Memory port and outputs come straight from registers.
   assign mem_bus.wr_en   = wr_q;
   assign mem_bus.wr_addr = wr_addr_q;
   assign mem_bus.wr_data = wr_data_q;
   assign mem_bus.rd_addr = rd_addr_q;
   assign so              = so_q;
   assign so_oe           = so_oe_q;
   assign wel_clear       = wel_clr_q;
   assign block_lock      = lock_q;
   assign otp_lock_flags  = flags_q;

endmodule

// ==== verif/fbl_monitor.sv ====
`timescale 1ns/10ps
// Watches the top-level pins for the timing of lock, latch and serial answers.
module fbl_monitor
   import fbl_pkg::*;
#(
   parameter int NUM_BLOCKS = 128
) (
   input wire logic                  clock,            // System clock.
   input wire logic                  resetn,           // Asynchronous reset, active low.
   input wire logic                  cs_n,             // Chip select pin.
   input wire logic                  sclk,             // Serial clock pin.
   input wire logic                  si,               // Serial data in.
   input wire logic                  so,               // Serial data out.
   input wire logic                  so_oe,            // Serial out enable.
   input wire logic                  write_latch_flag, // Latch state.
   input wire logic                  wel_clear,        // Latch clear pulse.
   input wire logic [NUM_BLOCKS-1:0] block_lock,       // Block lock bits.
   input wire logic [OTP_REGS-2:0]   otp_lock_flags    // Security register locks.
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   // Every relation is sampled on the system clock and muted in reset.
   wel_pulse_a: assert property (wel_clear |=> (!wel_clear) [*8])
      else $error("latch clear pulse too long");
   lock_uniform_a: assert property ((&block_lock) || !(|block_lock))
      else $error("block locks not uniform");
   lock_at_cs_a: assert property (
      $changed(block_lock) |-> cs_n && $past(cs_n, 2) && wel_clear)
      else $error("block locks changed outside a frame end");
   lock_latch_a: assert property ($changed(block_lock) |-> $past(write_latch_flag))
      else $error("block locks changed with latch clear");
   wel_at_cs_a: assert property (wel_clear |-> cs_n && $past(write_latch_flag))
      else $error("latch clear without a finished command");
   oe_idle_a: assert property (cs_n [*6] |-> !so_oe)
      else $error("serial out driven while deselected");
   so_steady_a: assert property (so_oe && $changed(so) |-> !$past(sclk))
      else $error("serial out moved while clock high");
   otp_sticky_a: assert property (
      (otp_lock_flags & $past(otp_lock_flags)) == $past(otp_lock_flags))
      else $error("security lock flag cleared");
   otp_latch_a: assert property (
      $changed(otp_lock_flags) |-> !cs_n && $past(write_latch_flag, 2))
      else $error("security lock set without latch");
endmodule

bind fbl_top fbl_monitor #(.NUM_BLOCKS(NUM_BLOCKS)) u_mon (.clock(clock), .resetn(resetn),
   .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe),
   .write_latch_flag(write_latch_flag), .wel_clear(wel_clear), .block_lock(block_lock),
   .otp_lock_flags(otp_lock_flags));

// ==== verif/fbl_host.sv ====
`timescale 1ns/10ps
// Host side of the link; sclk idles low and si toggles on each read bit and once as chip select rises.
module fbl_host (
   input  wire logic clock, // Pacing clock.
   output logic      cs_n,  // Chip select, active low.
   output logic      sclk,  // Serial clock, mode 0.
   output logic      si,    // Serial data to the device.
   input  wire logic so     // Serial data from the device.
);
   // Idle levels at time zero.
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si   = 1'b0;
   end

   // Waits falling edges so every pin change lands off the sampling edge.
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask

   // Sends nb bits of tx MSB first, then clocks nr bits back into rx.
   task automatic frame(input logic [63:0] tx, input int nb, input int nr,
                        output logic [15:0] rx);
      rx = 16'h0000;
      tick(1);
      cs_n = 1'b0;
      tick(4);
      for (int i = 0; i < nb + nr; i++) begin
         si = (i < nb) ? tx[63-i] : ~si;
         tick(4);
         sclk = 1'b1;
         tick(2);
         if (i >= nb) rx = {rx[14:0], so};
         tick(2);
         sclk = 1'b0;
      end
      tick(4);
      cs_n = 1'b1;
      si   = ~si;
      tick(8);
   endtask
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/10ps
// Drives lock, unlock, status reads and security programming against a behavioural model.
module tb;
   import fbl_pkg::*;
   localparam int NB = 128;
   logic                clock            = 1'b0;
   logic                resetn           = 1'b0;
   logic                write_latch_flag = 1'b0;
   logic                cs_n, sclk, si, so, so_oe, wel_clear;
   logic [NB-1:0]       block_lock;
   logic [OTP_REGS-2:0] otp_lock_flags;
   logic [15:0]         rx;
   logic [23:0]         a;
   logic [2:0]          otp_m = 3'h0;
   int                  miscompares = 0, cmp_count = 0, wel_seen = 0, wel_exp = 0, lock_m = 1;

   always #50 clock = ~clock;

   fbl_top #(.NUM_BLOCKS(NB)) i_fbl_top (.clock(clock), .resetn(resetn), .cs_n(cs_n),
      .sclk(sclk), .si(si), .so(so), .so_oe(so_oe), .write_latch_flag(write_latch_flag),
      .wel_clear(wel_clear), .block_lock(block_lock), .otp_lock_flags(otp_lock_flags));
   fbl_host host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so));

   // Counts clear pulses and drops the latch as its owner would.
   always @(negedge clock) begin
      if (wel_clear === 1'b1) begin
         wel_seen++;
         write_latch_flag = 1'b0;
      end
   end

   // Compares one value and reports a difference.
   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Reads the status of a random address over two repeated bytes.
   // Per-block protection counts as selected throughout; the answer is only compared.
   task automatic rd(input logic [7:0] op);
      a = 24'($urandom);
      host.frame({op, a, 32'h0}, 32, 16, rx);
      check("status", rx, {2{LOCK_PAD, 1'(lock_m)}});
      check("so_oe idle", so_oe, 1'b0);
   endtask

   // Global command of nb bits with the latch set as asked.
   task automatic glob(input logic [7:0] op, input int nb, input logic wl);
      write_latch_flag = wl;
      host.frame({op, 56'h0}, nb, 0, rx);
      if (wl && nb >= 8 && nb % 8 == 0) begin
         lock_m = (op == OP_GLOBAL_LOCK);
         wel_exp++;
      end
      check("block_lock", block_lock, {NB{1'(lock_m)}});
      check("wel pulses", wel_seen, wel_exp);
   endtask

   // Programs byte ofs of register sel with a non-erased value.
   // A frame that locks its register ends without a latch clear pulse.
   task automatic otp(input logic [1:0] sel, input logic wl, input logic [6:0] ofs);
      a = 24'($urandom);
      a[8:7] = sel;
      a[6:0] = ofs;
      write_latch_flag = wl;
      host.frame({OP_OTP_PROG, a, 8'($urandom_range(254, 0)), 24'h0}, 40, 0, rx);
      if (wl && sel != OTP_FACTORY && !otp_m[sel-1]) begin
         if (ofs == OTP_MSB_OFS) otp_m[sel-1] = 1'b1;
         else wel_exp++;
      end
      write_latch_flag = 1'b0;
      check("otp flags", otp_lock_flags, otp_m);
      check("wel pulses", wel_seen, wel_exp);
   endtask

   // Main sequence.
   initial begin
      void'($urandom(5126));
      repeat (10) @(negedge clock);
      resetn = 1'b1;
      repeat (6) @(negedge clock);
      check("lock after reset", block_lock, {NB{1'b1}});
      rd(OP_RD_LOCK_A);
      glob(OP_GLOBAL_UNLOCK, 8, 1'b0);
      glob(OP_GLOBAL_UNLOCK, 12, 1'b1);
      glob(OP_GLOBAL_UNLOCK, 8, 1'b1);
      rd(OP_RD_LOCK_B);
      rd(OP_RD_LOCK_A);
      glob(OP_GLOBAL_LOCK, 4, 1'b1);
      glob(OP_GLOBAL_LOCK, 16, 1'b1);
      rd(OP_RD_LOCK_B);
      for (int s = 0; s < OTP_REGS; s++) begin
         otp(2'(s), 1'b0, OTP_MSB_OFS);
         otp(2'(s), 1'b1, 7'($urandom_range(126, 0)));
         otp(2'(s), 1'b1, OTP_MSB_OFS);
         otp(2'(s), 1'b1, OTP_MSB_OFS);
      end
      print_verdict;
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (50000) @(posedge clock);
      miscompares++;
      print_verdict;
   end
endmodule
